// [rtl/pat_status.sv]
/*
 * port arbitration table status block: channel control, status and the
 * first two table words, an AHB-Lite slave, a latched copy of the table for
 * the arbiter and a skipping phase walker over that copy.
 * assumes one 10 MHz clock, a synchronous reset and single word transfers.
 */
// Behaviour
// - any table write sets coherency pending
// - coherency bit reads zero on downstream ports
// - coherency meaningful only for table-based schemes
// - bit 1 shows flow-control init pending
// - eight four-bit phase fields per word
// - invalid port entries skipped at one entry per cycle
// - codes 0,2,3,4 valid; 5..F reserved
// - table resets to rotating 1..7 pattern
// - load request write-one, reads zero, upstream only
// - three-bit arbitration select field held
`default_nettype none
`include "pat_cfg.svh"

module pat_status
    import pat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // port role and link state
    input wire logic is_upstream,
    input wire logic fc_init_done,
    input wire logic [7:0] egress_port_id,
    // arbiter side
    input wire logic phase_advance,
    output logic [3:0] grant_port,
    output logic grant_valid,
    output logic [2:0] arb_scheme,
    output logic table_loaded
);

    // bus data phase capture
    logic wr_pend_q;
    logic [`PAT_ADDR_MSB:0] addr_q;
    // software-visible registers
    logic [31:0] tbl0_q;
    logic [31:0] tbl1_q;
    logic [2:0] sel_q;
    logic coh_q;
    // arbiter copy of the table
    logic [31:0] act0_q;
    logic [31:0] act1_q;
    pat_load_state_t ld_q;
    logic [2:0] ld_cnt_q;
    logic [3:0] phase_q;
    logic [31:0] rdata_d;
    logic addr_ok;
    logic wr_tbl;
    logic load_req;

    // a phase code names a real port other than reserved codes
    function automatic logic port_valid(input logic [3:0] code);
        port_valid = (code == `PAT_PORT_0) || (code == `PAT_PORT_2) ||
                     (code == `PAT_PORT_3) || (code == `PAT_PORT_4);
    endfunction

    // pick phase field n of the active 16-entry copy
    function automatic logic [3:0] phase_code(input logic [31:0] w0,
                                              input logic [31:0] w1,
                                              input logic [3:0] n);
        logic [63:0] both;
        both = {w1, w0};
        phase_code = both[{n, 2'b00} +: `PAT_PHASE_W];
    endfunction

    // slave always ready: no wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = `PAT_HRESP_OKAY;
    assign addr_ok = hsel && hready && htrans[`PAT_HTRANS_NONSEQ_BIT];

    // address phase capture for writes; reads decode the live address
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend_q <= 1'b0;
            addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= addr_ok && hwrite;
            addr_q <= haddr[`PAT_ADDR_MSB:0];
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rdata_d = '0;
        case (haddr[`PAT_ADDR_MSB:0])
            `PAT_ADDR_STATUS: begin
                // reserved bits stay zero
                rdata_d[`PAT_STS_COHERENCY_BIT] = coh_q & is_upstream;
                rdata_d[`PAT_STS_NEGOTIATION_BIT] = ~fc_init_done;
            end
            `PAT_ADDR_CONTROL: begin
                // load request always reads zero
                rdata_d[`PAT_CTL_SEL_MSB:`PAT_CTL_SEL_LSB] = sel_q;
            end
            `PAT_ADDR_TBL0: rdata_d = tbl0_q;
            `PAT_ADDR_TBL1: rdata_d = tbl1_q;
            default: rdata_d = '0;
        endcase
    end

    // read data is registered at the address phase edge
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rdata_d;
        end
    end

    // decoded write strobes in the data phase
    assign wr_tbl = wr_pend_q &&
                    ((addr_q == `PAT_ADDR_TBL0) || (addr_q == `PAT_ADDR_TBL1));
    assign load_req = wr_pend_q && (addr_q == `PAT_ADDR_CONTROL) &&
                      hwdata[`PAT_CTL_LOAD_BIT] && is_upstream;

    // table words; writes to the status word fall through untouched
    always_ff @(posedge clk) begin
        if (srst) begin
            tbl0_q <= `PAT_TBL0_RESET;
            tbl1_q <= `PAT_TBL1_RESET;
        end else if (wr_pend_q) begin
            if (addr_q == `PAT_ADDR_TBL0) begin
                tbl0_q <= hwdata;
            end else if (addr_q == `PAT_ADDR_TBL1) begin
                tbl1_q <= hwdata;
            end
            // status address: write ignored
        end
    end

    // arbitration select field
    always_ff @(posedge clk) begin
        if (srst) begin
            sel_q <= '0;
        end else if (wr_pend_q && addr_q == `PAT_ADDR_CONTROL) begin
            sel_q <= hwdata[`PAT_CTL_SEL_MSB:`PAT_CTL_SEL_LSB];
        end
    end

    // loader: a load request copies the table over a fixed latch time
    always_ff @(posedge clk) begin
        if (srst) begin
            ld_q <= PAT_LD_IDLE;
            ld_cnt_q <= '0;
        end else begin
            case (ld_q)
                PAT_LD_IDLE: begin
                    if (load_req) begin
                        ld_q <= PAT_LD_BUSY;
                        ld_cnt_q <= `PAT_LOAD_CYCLES;
                    end
                end
                PAT_LD_BUSY: begin
                    if (ld_cnt_q == 3'h1) begin
                        ld_q <= PAT_LD_IDLE;
                    end
                    ld_cnt_q <= ld_cnt_q - 3'h1;
                end
                default: ld_q <= PAT_LD_IDLE;
            endcase
        end
    end

    // the latch happens at the last loader cycle, so a table write earlier in the load is
    // captured and the bit clears; a write in that last cycle leaves the bit set, since it was not captured
    always_ff @(posedge clk) begin
        if (srst) begin
            act0_q <= `PAT_TBL0_RESET;
            act1_q <= `PAT_TBL1_RESET;
        end else if (ld_q == PAT_LD_BUSY && ld_cnt_q == 3'h1) begin
            act0_q <= tbl0_q;
            act1_q <= tbl1_q;
        end
    end

    // coherency pending: a write sets, latch completion clears, set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            coh_q <= 1'b0;
        end else if (wr_tbl) begin
            coh_q <= 1'b1;
        end else if (ld_q == PAT_LD_BUSY && ld_cnt_q == 3'h1) begin
            coh_q <= 1'b0;
        end
    end

    // phase walker: advances on arbiter request, and skips invalid codes on its own at
    // one per cycle; entries naming the egress port are not guarded, the
    // result is left to software as undefined
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q <= '0;
        end else if (phase_advance || !port_valid(phase_code(act0_q, act1_q, phase_q))) begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // grant the current phase only when it names a valid port
    assign grant_port = phase_code(act0_q, act1_q, phase_q);
    assign grant_valid = port_valid(grant_port);
    assign arb_scheme = sel_q;
    // the table copy is in use; coherency only matters for table schemes
    assign table_loaded = ~coh_q;

endmodule

`default_nettype wire

// [common/pat_cfg.svh]
/*
 * register offsets, field positions, reset values and codes for the port
 * arbitration table status block.
 * assumes inclusion by bare name from the package and the design module.
 */
`ifndef PAT_CFG_SVH
`define PAT_CFG_SVH

// byte addresses of the registers
`define PAT_ADDR_STATUS 12'h218
`define PAT_ADDR_CONTROL 12'h214
`define PAT_ADDR_TBL0 12'h220
`define PAT_ADDR_TBL1 12'h224
`define PAT_ADDR_MSB 11
`define PAT_ADDR_WORD_LSB 2

// status bits
`define PAT_STS_COHERENCY_BIT 0
`define PAT_STS_NEGOTIATION_BIT 1

// control fields
`define PAT_CTL_LOAD_BIT 16
`define PAT_CTL_SEL_MSB 19
`define PAT_CTL_SEL_LSB 17

// table reset values, rotating 1..7 pattern
`define PAT_TBL0_RESET 32'h1765_4321
`define PAT_TBL1_RESET 32'h2176_5432

// phase field geometry
`define PAT_PHASE_W 4
`define PAT_PHASES 8

// port identifiers
`define PAT_PORT_0 4'h0
`define PAT_PORT_2 4'h2
`define PAT_PORT_3 4'h3
`define PAT_PORT_4 4'h4

// latch time taken by the arbiter after a load request, in cycles
`define PAT_LOAD_CYCLES 3'h4

// AHB transfer type and OKAY response
`define PAT_HTRANS_NONSEQ_BIT 1
`define PAT_HRESP_OKAY 1'b0

`endif

// [common/pat_pkg.sv]
/*
 * types shared by the port arbitration table status block.
 * assumes pat_cfg.svh on the include path.
 */
`default_nettype none
`include "pat_cfg.svh"

package pat_pkg;
    // loader state: idle or copying the table into the arbiter
    typedef enum logic [0:0] {
        PAT_LD_IDLE = 1'b0,
        PAT_LD_BUSY = 1'b1
    } pat_load_state_t;
endpackage

`default_nettype wire

// [bench/pat_status_chk.sv]
/* checker for pat_status: bus answers, status bits and table loading.
   assumes zero-wait single word AHB-Lite transfers on one clock. */
`default_nettype none
module pat_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // status and arbiter side
    input wire logic is_upstream,
    input wire logic fc_init_done,
    input wire logic [3:0] grant_port,
    input wire logic grant_valid,
    input wire logic [2:0] arb_scheme,
    input wire logic table_loaded
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic acc, rd_sts, ld;  // accepted transfer, status read, upstream load
    logic ctl_q;  // control write now in its data phase
    logic [3:0] win_q;  // cycles left in which a load may complete
    assign acc = hsel & hready & htrans[1];
    assign rd_sts = acc & !hwrite & (haddr[11:0] == 12'h218);
    assign ld = ctl_q & hwdata[16] & is_upstream;
    // remember the control write until its data arrives
    always_ff @(posedge clk) begin
        ctl_q <= !srst & acc & hwrite & (haddr[11:0] == 12'h214);
    end
    // window after a load; a rise of table_loaded outside it is a fault
    always_ff @(posedge clk) begin
        if (srst) win_q <= 4'h0;
        else if (ld) win_q <= 4'h8;
        else if (win_q != 4'h0) win_q <= win_q - 4'h1;
    end
    a_code_valid: assert property (grant_valid == (grant_port inside {4'h0, 4'h2, 4'h3, 4'h4}))
        else $error("grant_valid wrong for code");
    a_write_pends: assert property (acc && hwrite && haddr[11:3] == 9'h44 |-> ##2 !table_loaded)
        else $error("table write did not set pending");
    a_load_clears: assert property (ld |-> ##[1:8] table_loaded)
        else $error("load did not clear pending");
    a_no_early: assert property ($rose(table_loaded) |-> win_q != 4'h0)
        else $error("pending cleared without load");
    a_sts_upper: assert property (rd_sts |=> hrdata[31:2] == 30'h0)
        else $error("status upper bits set");
    a_down_zero: assert property (rd_sts && !is_upstream |=> !hrdata[0])
        else $error("downstream coherency bit set");
    a_sts_coh: assert property (rd_sts && is_upstream |=> hrdata[0] == !$past(table_loaded))
        else $error("coherency bit wrong");
    a_neg_pend: assert property (rd_sts |=> hrdata[1] == !$past(fc_init_done))
        else $error("negotiation bit wrong");
    a_load_zero: assert property (acc && !hwrite && haddr[11:0] == 12'h214 |=> !hrdata[16])
        else $error("load bit read as one");
    a_sel_held: assert property (ctl_q |=> arb_scheme == $past(hwdata[19:17]))
        else $error("select field not stored");
    c_load: cover property (ld);
    c_down_read: cover property (rd_sts && !is_upstream);
    c_ctl_write: cover property (ctl_q);
endmodule
bind pat_status pat_chk i_pat_chk (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .is_upstream, .fc_init_done, .grant_port, .grant_valid, .arb_scheme,
    .table_loaded);
`default_nettype wire

// [bench/testbench.sv]
/* self-checking bench for pat_status, registers reached over AHB-Lite.
   assumes the checker is bound from its own file. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, hsel, hwrite, is_upstream, fc_init_done, phase_advance;
    logic [31:0] haddr, hwdata, hrdata, rd_d;
    logic [1:0] htrans;
    logic hreadyout, hresp, grant_valid, table_loaded;
    logic [3:0] grant_port;
    logic [2:0] arb_scheme;
    int fails, tests_run;
    // hreadyout is the bus ready; word size and egress id are fixed
    pat_status i_pat_status (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .is_upstream,
        .fc_init_done, .egress_port_id(8'h0), .phase_advance, .grant_port, .grant_valid,
        .arb_scheme, .table_loaded);
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // one single transfer; waits on ready in both phases
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_d = hrdata;
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("read", rd_d, e);
    endtask
    task t_reset;
        rc(12'h220, 32'h1765_4321);
        rc(12'h224, 32'h2176_5432);
        rc(12'h218, 32'h0);
    endtask
    task t_pend;
        bus(1'b1, 12'h220, 32'h4320_4320);
        rc(12'h220, 32'h4320_4320);
        rc(12'h218, 32'h1);
        bus(1'b1, 12'h214, 32'h000b_0000);
        // the select field lands at the edge the task returns on; look once it settles
        @(negedge clk);
        chk("scheme", {29'h0, arb_scheme}, 32'h5);
        bus(1'b0, 12'h214, 32'h0);
        chk("load bit", {31'h0, rd_d[16]}, 32'h0);
        repeat (8) @(posedge clk);
        rc(12'h218, 32'h0);
    endtask
    // downstream: bit reads zero and load is ignored
    task t_down;
        is_upstream <= 1'b0;
        bus(1'b1, 12'h224, 32'h2222_3333);
        rc(12'h218, 32'h0);
        bus(1'b1, 12'h214, 32'h0001_0000);
        is_upstream <= 1'b1;
        repeat (8) @(posedge clk);
        rc(12'h218, 32'h1);
        bus(1'b1, 12'h214, 32'h0001_0000);
        repeat (8) @(posedge clk);
        rc(12'h218, 32'h0);
    endtask
    task t_neg;
        fc_init_done <= 1'b0;
        rc(12'h218, 32'h2);
        bus(1'b1, 12'h218, 32'hffff_ffff);
        rc(12'h218, 32'h2);
        fc_init_done <= 1'b1;
    endtask
    // every loaded code is valid, so each phase grants
    // the loaded copy holds six phases naming port 3, whichever phase the walk starts on
    task t_grant;
        int n3;
        n3 = 0;
        repeat (16) begin
            @(posedge clk);
            phase_advance <= 1'b1;
            @(negedge clk);
            chk("grant", {31'h0, grant_valid}, 32'h1);
            if (grant_port === 4'h3) n3++;
        end
        phase_advance <= 1'b0;
        chk("port 3 phases", n3, 32'h6);
    endtask
    task end_of_test;
        $display("checks %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // a hang ends the run as a failure
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test;
    end
    initial begin
        {srst, hsel, hwrite, is_upstream, fc_init_done, phase_advance} = 6'b100110;
        {haddr, hwdata, htrans, fails, tests_run} = '0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_pend;
        t_down;
        t_neg;
        t_grant;
        end_of_test;
    end
endmodule
`default_nettype wire
